//--- hw/lhp_regs.svh
// Constants of the host bus port: widths, strap codes, bit positions.
// Assumes inclusion by bare name from the package and the port modules.
`ifndef LHP_REGS_SVH
`define LHP_REGS_SVH

// Bus widths
`define LHP_ADDR_W      17
`define LHP_DATA_W      16
`define LHP_BYTE_W      8
`define LHP_LANES       2
`define LHP_MODE_W      3

// Strap codes for the mode pins, low bit is cfg_mode_bit0
`define LHP_MODE_GENERIC  3'h7
`define LHP_MODE_STROBE   3'h3
`define LHP_BS_GENERIC    1'h0

// Positions inside the strap word {endian, mode[2:0], bus status}
`define LHP_CFG_W         5
`define LHP_CFG_BS_BIT    0
`define LHP_CFG_MODE_LSB  1
`define LHP_CFG_ENDIAN    4

// Address bit that carries the lower byte strobe in strobe mode
`define LHP_ADDR_LDS_BIT  0

// Stages of every synchroniser
`define LHP_SYNC_STAGES   2

`endif

//--- hw/lhp_pkg.sv
// Types and decode helpers shared by the host bus port modules.
// Assumes the constants header sits beside it.
`include "lhp_regs.svh"

package lhp_pkg;

  // Host bus modes this port serves
  typedef enum logic [1:0] {
    LHP_BUS_NONE,
    LHP_BUS_GENERIC,
    LHP_BUS_STROBE
  } lhp_bus_mode_type;

  // Host clock side sequencer
  typedef enum logic [1:0] {
    L_IDLE,
    L_BUSY,
    L_DONE
  } lhp_link_state_type;

  // Core clock side sequencer
  typedef enum logic {
    C_IDLE,
    C_REQ
  } lhp_core_state_type;

  // Strap decode; unlisted codes leave the port deaf
  function automatic lhp_bus_mode_type lhp_decode_mode(
    input logic [`LHP_MODE_W-1:0] mode,
    input logic                   bs
  );
    if (mode == `LHP_MODE_GENERIC && bs == `LHP_BS_GENERIC)
      return LHP_BUS_GENERIC;
    else if (mode == `LHP_MODE_STROBE)
      return LHP_BUS_STROBE;
    else
      return LHP_BUS_NONE;
  endfunction

endpackage

//--- hw/lhp_sync.sv
// Two-flop level synchroniser, one per bit.
// Assumes the input is a level that stays put for several dst clocks.
`timescale 1ns/1ns

module lhp_sync
  import lhp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Destination clock
  input  wire logic             clk_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second; no reset so nothing else touches it
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_i) begin
        meta_q[gi] <= d_i[gi];
        sync_q[gi] <= meta_q[gi];
      end
    end
  endgenerate

  assign q_o = sync_q;

endmodule // lhp_sync

//--- hw/lhp_toggle_sync.sv
// Toggle to pulse crossing for one event between unrelated clocks.
// Assumes events are spaced by a full handshake round trip.
`timescale 1ns/1ns

module lhp_toggle_sync
  import lhp_pkg::*;
(
  // Destination clock and synchronous reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Source toggle and destination pulse
  input  wire logic tog_i,
  output logic      pulse_o
);

  logic tog_s;
  logic last_q;

  lhp_sync #(.WIDTH(1)) u_sync (
    .clk_i (clk_i),
    .d_i   (tog_i),
    .q_o   (tog_s)
  );

  // Edge memory sits after the second stage
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      last_q <= 1'b0;
    end else begin
      last_q <= tog_s;
    end
  end

  assign pulse_o = (tog_s != last_q) && rst_b_i;

endmodule // lhp_toggle_sync

//--- hw/lhp_host_port.sv
// Host bus port of the display controller: generic enable and strobe modes.
// Assumes host pins are synchronous to HOST_PORT_CLK_I and the core memory
// side answers each MEM_REQ_O with one MEM_ACK_I pulse on CLK_I.
`timescale 1ns/1ns
`include "lhp_regs.svh"

module lhp_host_port
  import lhp_pkg::*;
(
  // Core clock and reset
  input  wire logic                    CLK_I,
  input  wire logic                    RST_B_I,
  // Host port clock
  input  wire logic                    HOST_PORT_CLK_I,
  // Straps
  input  wire logic                    CFG_ENDIAN_I,
  input  wire logic [`LHP_MODE_W-1:0]  CFG_MODE_I,
  // Host bus control
  input  wire logic                    HOST_CS_B_I,
  input  wire logic                    BUS_STATUS_B_I,
  input  wire logic                    WR_EN_LO_B_I,
  input  wire logic                    WR_EN_HI_B_I,
  input  wire logic                    RD_EN_LO_B_I,
  input  wire logic                    RD_WR_I,
  output logic                         WAIT_B_O,
  // Host address and data
  input  wire logic [`LHP_ADDR_W-1:0]  HOST_ADDR_I,
  input  wire logic [`LHP_DATA_W-1:0]  HOST_DATA_I,
  output logic      [`LHP_DATA_W-1:0]  HOST_DATA_O,
  output logic      [`LHP_LANES-1:0]   HOST_DATA_OE_O,
  // Core memory side
  output logic                         MEM_REQ_O,
  output logic                         MEM_WE_O,
  output logic      [`LHP_ADDR_W-1:0]  MEM_ADDR_O,
  output logic      [`LHP_DATA_W-1:0]  MEM_WDATA_O,
  output logic      [`LHP_LANES-1:0]   MEM_BE_O,
  input  wire logic                    MEM_ACK_I,
  input  wire logic [`LHP_DATA_W-1:0]  MEM_RDATA_I,
  // Latched configuration
  output logic                         CFG_ENDIAN_O,
  output logic      [`LHP_MODE_W-1:0]  CFG_MODE_O,
  output logic                         CFG_BS_O
);

  // ---------------- Core clock domain ----------------
  logic [`LHP_CFG_W-1:0]   strap_s;
  logic [`LHP_CFG_W-1:0]   cfg_q;
  logic                    cfg_endian_w;
  lhp_core_state_type      cst_q;
  logic                    core_req_pulse;
  logic                    ack_tog_q;
  logic                    mem_req_q;
  logic                    mem_we_q;
  logic [`LHP_ADDR_W-1:0]  mem_addr_q;
  logic [`LHP_DATA_W-1:0]  mem_wdata_q;
  logic [`LHP_LANES-1:0]   mem_be_q;
  logic [`LHP_DATA_W-1:0]  core_rdata_q;
  logic [`LHP_DATA_W-1:0]  rdata_swap_w;

  // ---------------- Host clock domain ----------------
  logic                    link_rst_s;
  logic                    link_rst_b_q;
  logic [`LHP_CFG_W-1:0]   cfg_link_s;
  lhp_bus_mode_type        mode_w;
  logic                    generic_w;
  logic                    strobe_w;
  lhp_link_state_type      lst_q;
  logic                    req_tog_q;
  logic                    link_ack_pulse;
  logic                    sel_w;
  logic [`LHP_LANES-1:0]   wr_be_w;
  logic [`LHP_LANES-1:0]   rd_be_w;
  logic [`LHP_LANES-1:0]   strobe_be_w;
  logic [`LHP_LANES-1:0]   be_w;
  logic                    is_write_w;
  logic                    access_w;
  logic                    start_w;
  logic [`LHP_ADDR_W-1:0]  addr_w;
  logic                    bnd_we_q;
  logic [`LHP_ADDR_W-1:0]  bnd_addr_q;
  logic [`LHP_DATA_W-1:0]  bnd_wdata_q;
  logic [`LHP_LANES-1:0]   bnd_be_q;
  logic [`LHP_DATA_W-1:0]  host_rdata_q;

  // Straps pass two flops before the latch reads them
  lhp_sync #(.WIDTH(`LHP_CFG_W)) u_strap_sync (
    .clk_i (CLK_I),
    .d_i   ({CFG_ENDIAN_I, CFG_MODE_I, BUS_STATUS_B_I}),
    .q_o   (strap_s)
  );

  // Follow straps during reset; value at release stays frozen
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      cfg_q <= strap_s;
    end
  end

  assign cfg_endian_w = cfg_q[`LHP_CFG_ENDIAN];
  assign CFG_ENDIAN_O = cfg_endian_w;
  assign CFG_MODE_O   = cfg_q[`LHP_CFG_MODE_LSB +: `LHP_MODE_W];
  assign CFG_BS_O     = cfg_q[`LHP_CFG_BS_BIT];

  // Request event from the host side
  lhp_toggle_sync u_req_sync (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .tog_i   (req_tog_q),
    .pulse_o (core_req_pulse)
  );

  // Big endian straps swap the byte lanes of read data from the core
  assign rdata_swap_w = cfg_endian_w ?
      {MEM_RDATA_I[`LHP_BYTE_W-1:0],
       MEM_RDATA_I[`LHP_DATA_W-1:`LHP_BYTE_W]} : MEM_RDATA_I;

  // Core sequencer; bundle is stable while the request toggle is open
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      cst_q     <= C_IDLE;
      mem_req_q <= 1'b0;
      ack_tog_q <= 1'b0;
    end else begin
      unique case (cst_q)
        C_IDLE: begin
          if (core_req_pulse) begin
            cst_q     <= C_REQ;
            mem_req_q <= 1'b1;
          end
        end
        C_REQ: begin
          if (MEM_ACK_I) begin
            cst_q     <= C_IDLE;
            mem_req_q <= 1'b0;
            ack_tog_q <= ~ack_tog_q;
          end
        end
      endcase
    end
  end

  // Core side data registers
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      mem_we_q     <= 1'b0;
      mem_addr_q   <= '0;
      mem_wdata_q  <= '0;
      mem_be_q     <= '0;
      core_rdata_q <= '0;
    end else begin
      if (core_req_pulse && cst_q == C_IDLE) begin
        mem_we_q    <= bnd_we_q;
        mem_addr_q  <= bnd_addr_q;
        mem_wdata_q <= cfg_endian_w ?
            {bnd_wdata_q[`LHP_BYTE_W-1:0],
             bnd_wdata_q[`LHP_DATA_W-1:`LHP_BYTE_W]} : bnd_wdata_q;
        mem_be_q    <= cfg_endian_w ? {bnd_be_q[0], bnd_be_q[1]} : bnd_be_q;
      end
      if (cst_q == C_REQ && MEM_ACK_I && !mem_we_q) begin
        core_rdata_q <= rdata_swap_w;
      end
    end
  end

  assign MEM_REQ_O   = mem_req_q;
  assign MEM_WE_O    = mem_we_q;
  assign MEM_ADDR_O  = mem_addr_q;
  assign MEM_WDATA_O = mem_wdata_q;
  assign MEM_BE_O    = mem_be_q;

  // Reset into the host domain, one extra stage so the straps settle first
  lhp_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i (HOST_PORT_CLK_I),
    .d_i   (RST_B_I),
    .q_o   (link_rst_s)
  );

  always_ff @(posedge HOST_PORT_CLK_I) begin
    link_rst_b_q <= link_rst_s;
  end

  // Latched straps are static after reset, a level crossing suffices
  lhp_sync #(.WIDTH(`LHP_CFG_W)) u_cfg_sync (
    .clk_i (HOST_PORT_CLK_I),
    .d_i   (cfg_q),
    .q_o   (cfg_link_s)
  );

  assign mode_w = lhp_decode_mode(
      cfg_link_s[`LHP_CFG_MODE_LSB +: `LHP_MODE_W],
      cfg_link_s[`LHP_CFG_BS_BIT]);
  assign generic_w = (mode_w == LHP_BUS_GENERIC);
  assign strobe_w  = (mode_w == LHP_BUS_STROBE);

  // Per-mode pin meaning; bus status ignored in generic mode
  assign wr_be_w     = {~WR_EN_HI_B_I, ~WR_EN_LO_B_I};
  assign rd_be_w     = {~RD_WR_I, ~RD_EN_LO_B_I};
  assign strobe_be_w = {~WR_EN_HI_B_I,
                        ~HOST_ADDR_I[`LHP_ADDR_LDS_BIT]};
  assign sel_w       = ~HOST_CS_B_I;
  assign is_write_w  = generic_w ? (|wr_be_w) : ~RD_WR_I;
  assign be_w        = strobe_w ? strobe_be_w :
                       ((|wr_be_w) ? wr_be_w : rd_be_w);
  assign access_w    = sel_w && (|be_w) &&
                       (generic_w || (strobe_w && !BUS_STATUS_B_I));
  assign start_w     = (lst_q == L_IDLE) && access_w;

  // Full byte address in generic mode, word address in strobe mode
  assign addr_w = strobe_w ?
      {HOST_ADDR_I[`LHP_ADDR_W-1:1], 1'b0} : HOST_ADDR_I;

  // Answer event from the core side
  lhp_toggle_sync u_ack_sync (
    .clk_i   (HOST_PORT_CLK_I),
    .rst_b_i (link_rst_b_q),
    .tog_i   (ack_tog_q),
    .pulse_o (link_ack_pulse)
  );

  // Host sequencer, clocked by the host port clock
  always_ff @(posedge HOST_PORT_CLK_I) begin
    if (!link_rst_b_q) begin
      lst_q     <= L_IDLE;
      req_tog_q <= 1'b0;
    end else begin
      unique case (lst_q)
        L_IDLE: begin
          if (start_w) begin
            lst_q     <= L_BUSY;
            req_tog_q <= ~req_tog_q;
          end
        end
        L_BUSY: begin
          if (link_ack_pulse) begin
            lst_q <= L_DONE;
          end
        end
        L_DONE: begin
          if (!access_w) begin
            lst_q <= L_IDLE;
          end
        end
      endcase
    end
  end

  // Transfer bundle held from request until answer
  always_ff @(posedge HOST_PORT_CLK_I) begin
    if (!link_rst_b_q) begin
      bnd_we_q     <= 1'b0;
      bnd_addr_q   <= '0;
      bnd_wdata_q  <= '0;
      bnd_be_q     <= '0;
      host_rdata_q <= '0;
    end else begin
      if (start_w) begin
        bnd_we_q    <= is_write_w;
        bnd_addr_q  <= addr_w;
        bnd_wdata_q <= HOST_DATA_I;
        bnd_be_q    <= be_w;
      end
      if (lst_q == L_BUSY && link_ack_pulse) begin
        host_rdata_q <= core_rdata_q;
      end
    end
  end

  // Wait low while busy in generic mode; acknowledge low when done in strobe
  assign WAIT_B_O = generic_w ? !(access_w && lst_q != L_DONE) :
                    !(access_w && lst_q == L_DONE);

  // Read bytes driven only once answered (L_DONE) and while the enables stay
  assign HOST_DATA_O    = host_rdata_q;
  assign HOST_DATA_OE_O = (lst_q == L_DONE && !bnd_we_q && access_w) ?
                          (be_w & bnd_be_q) : '0;

  // ---------------- Checks ----------------
  sequence s_start;
    (lst_q == L_IDLE) && access_w;
  endsequence

  sequence s_core_ack;
    mem_req_q ##0 MEM_ACK_I;
  endsequence

  AST_GEN_WAIT: assert property (
    @(posedge HOST_PORT_CLK_I) disable iff (!link_rst_b_q)
    (generic_w && lst_q == L_BUSY && access_w) |-> !WAIT_B_O)
    else $error("wait not held in generic busy cycle");

  AST_STROBE_ACK: assert property (
    @(posedge HOST_PORT_CLK_I) disable iff (!link_rst_b_q)
    (strobe_w && lst_q == L_DONE && access_w) |-> !WAIT_B_O)
    else $error("acknowledge missing after answer");

  AST_NO_EARLY_ACK: assert property (
    @(posedge HOST_PORT_CLK_I) disable iff (!link_rst_b_q)
    (strobe_w && lst_q != L_DONE) |-> WAIT_B_O)
    else $error("acknowledge before answer");

  AST_START_REQ: assert property (
    @(posedge HOST_PORT_CLK_I) disable iff (!link_rst_b_q)
    s_start |=> (lst_q == L_BUSY) && (req_tog_q != $past(req_tog_q)))
    else $error("selected access not started");

  AST_STROBE_BE: assert property (
    @(posedge HOST_PORT_CLK_I) disable iff (!link_rst_b_q)
    (s_start and strobe_w) |=> bnd_be_q ==
      {!$past(WR_EN_HI_B_I), !$past(HOST_ADDR_I[0])} && !bnd_addr_q[0])
    else $error("strobe byte lanes or word address wrong");

  AST_STROBE_DIR: assert property (
    @(posedge HOST_PORT_CLK_I) disable iff (!link_rst_b_q)
    (s_start and strobe_w) |=> bnd_we_q == !$past(RD_WR_I))
    else $error("strobe direction wrong");

  AST_GEN_RD_BE: assert property (
    @(posedge HOST_PORT_CLK_I) disable iff (!link_rst_b_q)
    (s_start and generic_w and !is_write_w) |=>
      bnd_be_q == {!$past(RD_WR_I), !$past(RD_EN_LO_B_I)})
    else $error("generic read lanes wrong");

  AST_BS_GATE: assert property (
    @(posedge HOST_PORT_CLK_I) disable iff (!link_rst_b_q)
    (lst_q == L_IDLE && strobe_w && BUS_STATUS_B_I) |=> lst_q == L_IDLE)
    else $error("strobe access without valid address");

  AST_READ_DRIVE: assert property (
    @(posedge HOST_PORT_CLK_I) disable iff (!link_rst_b_q)
    (|HOST_DATA_OE_O) |-> (lst_q == L_DONE && !bnd_we_q && access_w))
    else $error("data driven outside read hold");

  AST_REQ_STABLE: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (mem_req_q && !MEM_ACK_I) |=> mem_req_q && $stable(mem_addr_q))
    else $error("memory request dropped before answer");

  AST_REQ_END: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_core_ack |=> !mem_req_q && (ack_tog_q != $past(ack_tog_q)))
    else $error("answer not returned to host side");

  AST_CFG_FROZEN: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    $past(RST_B_I) |-> $stable(cfg_q))
    else $error("configuration changed after reset");

endmodule // lhp_host_port

//--- testbench/lhp_host_model.sv
// Host processor model with its glue: generic enables or strobe bus.
// Assumes pins are launched on the host clock and the port answers on WAIT.
`timescale 1ns/1ns
`include "lhp_regs.svh"

module lhp_host_model
  import lhp_pkg::*;
(
  // Host clock
  input  wire logic                   clk_i,
  // Answer from the port
  input  wire logic                   wait_b_i,
  input  wire logic [`LHP_DATA_W-1:0] data_i,
  // Control, address and data to the port
  output logic                        cs_b_o,
  output logic                        bs_b_o,
  output logic                        we_lo_b_o,
  output logic                        we_hi_b_o,
  output logic                        rd_lo_b_o,
  output logic                        rd_wr_o,
  output logic [`LHP_ADDR_W-1:0]      addr_o,
  output logic [`LHP_DATA_W-1:0]      data_o
);
  // Idle bus; status low so the generic strap is seen at reset
  initial begin
    cs_b_o    = 1'b1;
    bs_b_o    = 1'b0;
    we_lo_b_o = 1'b1;
    we_hi_b_o = 1'b1;
    rd_lo_b_o = 1'b1;
    rd_wr_o   = 1'b1;
    addr_o    = '0;
    data_o    = '0;
  end

  // One access; pins held until the answer edge, then released
  task automatic access(input logic strobe, input logic wr, input logic bs,
                        input logic [16:0] addr, input logic [1:0] lanes,
                        input logic [15:0] wdata, input int lim,
                        output logic [15:0] rdata, output logic ok);
    int n;
    @(posedge clk_i);
    cs_b_o <= 1'b0;
    addr_o <= strobe ? {addr[16:1], ~lanes[0]} : addr;
    data_o <= wdata;
    if (strobe) begin
      bs_b_o    <= bs;
      we_hi_b_o <= ~lanes[1];
      rd_wr_o   <= ~wr;
    end else begin
      we_lo_b_o <= ~(wr & lanes[0]);
      we_hi_b_o <= ~(wr & lanes[1]);
      rd_lo_b_o <= ~(~wr & lanes[0]);
      rd_wr_o   <= ~(~wr & lanes[1]);
    end
    ok = 1'b0;
    rdata = '0;
    // Generic is done on wait release, strobe on acknowledge low
    for (n = 0; n < lim && !ok; n++) begin
      @(posedge clk_i);
      ok = (wait_b_i === ~strobe);
      rdata = data_i;
    end
    cs_b_o    <= 1'b1;
    bs_b_o    <= strobe;
    we_lo_b_o <= 1'b1;
    we_hi_b_o <= 1'b1;
    rd_lo_b_o <= 1'b1;
    rd_wr_o   <= 1'b1;
    addr_o    <= ~addr;
    data_o    <= ~wdata; // Released lines do not keep old value
    repeat (2) @(posedge clk_i);
  endtask
endmodule // lhp_host_model

//--- testbench/lcd_ctrl_host_bus_port_tb_top.sv
// Self-checking bench of the host bus port with a host model and a memory.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ns
`include "lhp_regs.svh"

module lcd_ctrl_host_bus_port_tb_top;
  import lhp_pkg::*;

  // Clocks, reset, straps and core memory side
  logic        clk = 1'b0, hclk = 1'b0, rst_b = 1'b0, endian = 1'b0;
  logic [2:0]  mode = `LHP_MODE_GENERIC;
  logic        mem_ack = 1'b0, mem_req, mem_we, wait_b;
  logic [15:0] mem_rdata = '0, dout, hdrv, mem_wdata;
  logic [16:0] mem_addr, haddr;
  logic [1:0]  oe, mem_be;
  logic        cs_b, bs_b, we_lo_b, we_hi_b, rd_lo_b, rd_wr;
  logic        cfg_endian, cfg_bs;
  logic [2:0]  cfg_mode;
  logic [16:0] cap_addr;
  logic [15:0] cap_wdata, rd;
  logic [1:0]  cap_be;
  logic        cap_we, ok;
  int          n_errors = 0, check_count = 0, n_acks = 0, cnt = 0;
  int          mem_lat = 2;
  wire  [15:0] hwire = {oe[1] ? dout[15:8] : hdrv[15:8],
                        oe[0] ? dout[7:0]  : hdrv[7:0]};

  // Core clock, and an unrelated host clock
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #40 hclk = ~hclk;
  end

  lhp_host_port DUT (
    .CLK_I(clk), .RST_B_I(rst_b), .HOST_PORT_CLK_I(hclk),
    .CFG_ENDIAN_I(endian), .CFG_MODE_I(mode), .HOST_CS_B_I(cs_b),
    .BUS_STATUS_B_I(bs_b), .WR_EN_LO_B_I(we_lo_b), .WR_EN_HI_B_I(we_hi_b),
    .RD_EN_LO_B_I(rd_lo_b), .RD_WR_I(rd_wr), .WAIT_B_O(wait_b),
    .HOST_ADDR_I(haddr), .HOST_DATA_I(hwire), .HOST_DATA_O(dout),
    .HOST_DATA_OE_O(oe), .MEM_REQ_O(mem_req), .MEM_WE_O(mem_we),
    .MEM_ADDR_O(mem_addr), .MEM_WDATA_O(mem_wdata), .MEM_BE_O(mem_be),
    .MEM_ACK_I(mem_ack), .MEM_RDATA_I(mem_rdata),
    .CFG_ENDIAN_O(cfg_endian), .CFG_MODE_O(cfg_mode), .CFG_BS_O(cfg_bs));

  lhp_host_model hm (
    .clk_i(hclk), .wait_b_i(wait_b), .data_i(hwire), .cs_b_o(cs_b),
    .bs_b_o(bs_b), .we_lo_b_o(we_lo_b), .we_hi_b_o(we_hi_b),
    .rd_lo_b_o(rd_lo_b), .rd_wr_o(rd_wr), .addr_o(haddr), .data_o(hdrv));

  // Core memory stand-in; latency varies to mimic refresh contention
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    if (!mem_req) begin
      cnt <= 0;
    end else if (!mem_ack) begin
      cnt <= cnt + 1;
      if (cnt == mem_lat) begin
        mem_ack   <= 1'b1;
        n_acks    <= n_acks + 1;
        cap_we    <= mem_we;
        cap_addr  <= mem_addr;
        cap_wdata <= mem_wdata;
        cap_be    <= mem_be;
      end
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Straps held well before and through the reset release
  task automatic do_reset(input logic [2:0] m, input logic e);
    @(posedge clk);
    rst_b  <= 1'b0;
    mode   <= m;
    endian <= e;
    repeat (40) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask

  task automatic t_gen_write();
    logic [15:0] mk;
    int          n0;
    check("mode", 32'(`LHP_MODE_GENERIC), 32'(cfg_mode));
    check("bs strap", 32'h0, 32'(cfg_bs));
    for (int l = 1; l < 4; l++) begin
      mem_lat = l * 4;
      n0 = n_acks;
      mk = {{8{l[1]}}, {8{l[0]}}};
      hm.access(1'b0, 1'b1, 1'b0, 17'h10a46, l[1:0], 16'hbeef, 200, rd, ok);
      check("wait release", 32'h1, 32'(ok));
      check("one request", 32'(n0 + 1), 32'(n_acks));
      check("write", 32'h1, 32'(cap_we));
      check("addr", 32'h10a46, 32'(cap_addr));
      check("lanes", 32'(l[1:0]), 32'(cap_be));
      check("wdata", 32'(16'hbeef & mk), 32'(cap_wdata & mk));
    end
    $display("test generic write done");
  endtask

  task automatic t_gen_read();
    logic [15:0] mk;
    @(posedge clk);
    mem_rdata <= 16'h5aa5;
    for (int l = 1; l < 4; l++) begin
      mem_lat = 7 - 2 * l;
      mk = {{8{l[1]}}, {8{l[0]}}};
      hm.access(1'b0, 1'b0, 1'b0, 17'h00011, l[1:0], 16'h0000, 200, rd, ok);
      check("wait release", 32'h1, 32'(ok));
      check("read", 32'h0, 32'(cap_we));
      check("rdata", 32'(16'h5aa5 & mk), 32'(rd));
      check("oe idle", 32'h0, 32'(oe));
    end
    $display("test generic read done");
  endtask

  task automatic t_strobe();
    do_reset(`LHP_MODE_STROBE, 1'b1);
    check("mode", 32'(`LHP_MODE_STROBE), 32'(cfg_mode));
    check("endian", 32'h1, 32'(cfg_endian));
    hm.access(1'b1, 1'b1, 1'b0, 17'h01235, 2'b11, 16'hbeef, 200, rd, ok);
    check("ack", 32'h1, 32'(ok));
    check("write", 32'h1, 32'(cap_we));
    check("word addr", 32'h01234, 32'(cap_addr));
    check("swapped data", 32'hefbe, 32'(cap_wdata));
    hm.access(1'b1, 1'b1, 1'b0, 17'h01235, 2'b01, 16'h00aa, 200, rd, ok);
    check("lower strobe", 32'h2, 32'(cap_be));
    @(posedge clk);
    mem_rdata <= 16'h1234;
    hm.access(1'b1, 1'b0, 1'b0, 17'h00040, 2'b01, 16'h0000, 200, rd, ok);
    check("ack", 32'h1, 32'(ok));
    check("read", 32'h0, 32'(cap_we));
    check("lower rdata", 32'h0012, 32'(rd));
    hm.access(1'b1, 1'b0, 1'b0, 17'h00040, 2'b10, 16'h0000, 200, rd, ok);
    check("upper rdata", 32'h3400, 32'(rd));
    check("oe idle", 32'h0, 32'(oe));
    $display("test strobe done");
  endtask

  task automatic t_refused();
    int n0;
    n0 = n_acks;
    hm.access(1'b1, 1'b1, 1'b1, 17'h00100, 2'b11, 16'h1111, 20, rd, ok);
    check("no ack", 32'h0, 32'(ok));
    check("no request", 32'(n0), 32'(n_acks));
    do_reset(`LHP_MODE_GENERIC, 1'b0);
    check("bs strap", 32'h1, 32'(cfg_bs));
    hm.access(1'b0, 1'b1, 1'b0, 17'h00100, 2'b11, 16'h2222, 20, rd, ok);
    check("deaf port", 32'(n0), 32'(n_acks));
    check("deaf wait", 32'h1, 32'(wait_b));
    $display("test refused done");
  endtask

  // Main sequence
  initial begin
    do_reset(`LHP_MODE_GENERIC, 1'b0);
    t_gen_write();
    t_gen_read();
    t_strobe();
    t_refused();
    final_report();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule // lcd_ctrl_host_bus_port_tb_top
